// *** pkg/ccs_pkg.sv ***
// Purpose: Shared constants and types of the compare/skip core
// Assumes: One clock, AXI4-Lite slave with 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package ccs_pkg;

  //////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] CCS_CTRL_OFS  = 8'h00;
  localparam logic [7:0] CCS_WORKING_REG_OFS  = 8'h04;
  localparam logic [7:0] CCS_BANK_OFS  = 8'h08;
  localparam logic [7:0] CCS_INDEX_OFS = 8'h0c;
  localparam logic [7:0] CCS_INSTR_OFS = 8'h10;
  localparam logic [7:0] CCS_STAT_OFS  = 8'h14;
  localparam logic [7:0] CCS_FADDR_OFS = 8'h18;
  localparam logic [7:0] CCS_FDATA_OFS = 8'h1c;
  localparam logic [7:0] CCS_WDOG_OFS  = 8'h20;

  // Field positions
  localparam int CCS_CTRL_EXT  = 0;
  localparam int CCS_INSTR_TWO = 16;
  localparam int CCS_ST_BUSY   = 0;
  localparam int CCS_ST_SKIP   = 1;
  localparam int CCS_ST_NEG    = 2;
  localparam int CCS_ST_ZERO   = 3;
  localparam int CCS_ST_TO     = 4;
  localparam int CCS_ST_PD     = 5;
  localparam int CCS_ST_BAD    = 6;
  localparam int CCS_ST_CYC    = 8;
  localparam int CCS_WD_POST   = 8;

  // Reset values
  localparam logic [7:0]  CCS_WORKING_REG_RST  = 8'h00;
  localparam logic [3:0]  CCS_BANK_RST  = 4'h0;
  localparam logic [11:0] CCS_INDEX_RST = 12'h000;
  localparam logic [11:0] CCS_FADDR_RST = 12'h000;
  localparam logic        CCS_EXT_RST   = 1'b0;
  localparam logic        CCS_FLAGN_RST = 1'b1;

  // Opcode patterns
  localparam logic [15:0] CCS_OP_WDCLR = 16'h0004;
  localparam logic [5:0]  CCS_OP_COMPLEMENT_REG_INSTR  = 6'h07;
  localparam logic [3:0]  CCS_OP_CPF   = 4'h6;
  localparam logic [2:0]  CCS_CPF_LT   = 3'h0;
  localparam logic [2:0]  CCS_CPF_EQ   = 3'h1;
  localparam logic [2:0]  CCS_CPF_GT   = 3'h2;

  // Addressing
  localparam logic [7:0] CCS_IDX_MAX  = 8'h5f;
  localparam logic [3:0] CCS_ACC_LOW  = 4'h0;
  localparam logic [3:0] CCS_ACC_HIGH = 4'hf;

  // Timing: quarter-cycles per instruction cycle, minus one
  localparam logic [1:0] CCS_QTR_LAST = 2'h3;

  // Watchdog widths and bus answers
  localparam int         CCS_WD_W     = 8;
  localparam int         CCS_PS_W     = 4;
  localparam logic [1:0] CCS_RESP_OK  = 2'h0;
  localparam logic [1:0] CCS_RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    CCS_IDLE  = 2'b00,
    CCS_EXEC  = 2'b01,
    CCS_SKIP1 = 2'b10,
    CCS_SKIP2 = 2'b11
  } ccs_state_t;

  typedef enum logic [2:0] {
    CCS_K_NONE  = 3'b000,
    CCS_K_WDCLR = 3'b001,
    CCS_K_COMPLEMENT_REG_INSTR  = 3'b010,
    CCS_K_CPFEQ = 3'b011,
    CCS_K_CPFGT = 3'b100,
    CCS_K_CPFLT = 3'b101
  } ccs_kind_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } ccs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } ccs_axi_rsp_t;

endpackage

// *** design/ccs_wdog.sv ***
// Purpose: Watchdog counter with postscaler
// Assumes: Tick is one pulse per instruction cycle
// Notes:   Clear wins over a tick in the same cycle
`timescale 1ns/100ps
`default_nettype none
module ccs_wdog
  import ccs_pkg::*;
(
  input  wire logic                clk,     // System clock
  input  wire logic                rst,     // Async reset, high
  input  wire logic                ce,      // Clock enable
  input  wire logic                tick,    // Instruction cycle end
  input  wire logic                clr,     // Clear counter and post
  output var  logic [CCS_WD_W-1:0] count_q, // Counter value
  output var  logic [CCS_PS_W-1:0] post_q   // Postscaler value
);

  //////////////////////////////////////////////////////////////////////
  // Counter advances on each tick; its wrap feeds postscaler
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_q <= '0;
      post_q  <= '0;
    end
    else if (ce)
    begin
      if (clr)
      begin
        count_q <= '0;
        post_q  <= '0;
      end
      else if (tick)
      begin
        count_q <= count_q + 1'b1;
        if (&count_q)
          post_q <= post_q + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** design/ccs_core.sv ***
// Purpose: Execution of watchdog-clear, complement and compare-skip
// Assumes: AXI4-Lite master feeds instructions one word at a time
// Notes:   Each instruction cycle is four quarter-cycles of CLK_SYS
//
// Operation
// - 0x0004 is watchdog clear, one cycle
// - Watchdog clear zeroes counter and postscaler
// - Watchdog clear sets time-out, power-down flags
// - 000111da ffff ffff complements a register
// - d=0 writes working reg, d=1 file
// - Complement updates only negative and zero
// - a=0 access bank, a=1 bank select
// - a=0, extended, f<=5F uses indexed offset
// - 0110001a ffff ffff is compare-skip equal
// - 0110010a ffff ffff is compare-skip greater
// - 0110000a ffff ffff is compare-skip less
// - Compares are unsigned, store nothing, no flags
// - Equal compare skips when file equals working
// - Greater compare skips when file is greater
// - Less compare skips when file is less
// - Taken skip adds one no-operation cycle
// - Skip over two-word instruction adds two
`timescale 1ns/100ps
`default_nettype none
module ccs_core
  import ccs_pkg::*;
(
  input  wire logic                  CLK_SYS,   // 100 MHz clock
  input  wire logic                  RST,       // Async reset, high
  input  wire logic                  CE,        // Clock enable
  input  wire ccs_pkg::ccs_axi_req_t AXI_REQ,   // Bus from master
  output var  ccs_pkg::ccs_axi_rsp_t AXI_RSP,   // Bus to master
  output var  logic [7:0]            WDOG_CNT,  // Watchdog counter
  output var  logic [3:0]            WDOG_POST, // Watchdog postscaler
  output var  logic                  BUSY,      // Instruction in flight
  output var  logic                  SKIP       // Skip cycle running
);

  //////////////////////////////////////////////////////////////////////
  // Declarations
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        aw_full_q;
  logic        w_full_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_do;
  logic [31:0] wmask;
  logic        wr_ok;
  logic        rd_ok;
  logic [31:0] rd_word;

  logic        ext_q;
  logic [7:0]  working_reg_q;
  logic [3:0]  bank_q;
  logic [11:0] index_q;
  logic [11:0] faddr_q;
  logic        neg_q;
  logic        zero_q;
  logic        to_n_q;
  logic        pd_n_q;
  logic        bad_q;
  logic        skip_q;
  logic [1:0]  cyc_q;

  ccs_state_t  state_q;
  logic [1:0]  qtr_q;
  logic [15:0] ir_q;
  logic        two_q;
  ccs_kind_t   kind_q;
  logic [11:0] ea_q;
  logic [7:0]  opnd_q;
  logic [7:0]  res_q;
  logic        take_q;
  logic        start;
  logic        q_end;
  logic        wd_clr;
  logic        wd_tick;
  logic        mem_we;
  logic [7:0]  mem [0:4095];
  logic [7:0]  wd_cnt;
  logic [3:0]  wd_post;

  //////////////////////////////////////////////////////////////////////
  // Instruction class from the opcode pattern
  function automatic ccs_kind_t decode(input logic [15:0] op);
    ccs_kind_t k;
    k = CCS_K_NONE;
    if (op == CCS_OP_WDCLR)
      k = CCS_K_WDCLR;
    else if (op[15:10] == CCS_OP_COMPLEMENT_REG_INSTR)
      k = CCS_K_COMPLEMENT_REG_INSTR;
    else if (op[15:12] == CCS_OP_CPF)
    begin
      case (op[11:9])
        CCS_CPF_EQ: k = CCS_K_CPFEQ;
        CCS_CPF_GT: k = CCS_K_CPFGT;
        CCS_CPF_LT: k = CCS_K_CPFLT;
        default:    k = CCS_K_NONE;
      endcase
    end
    return k;
  endfunction

  // Operand address from bank bit, file address and mode
  function automatic logic [11:0] eff_addr(input logic [15:0] op,
                                           input logic ext,
                                           input logic [3:0] bank_select_reg,
                                           input logic [11:0] idx);
    logic [11:0] a;
    a = {bank_select_reg, op[7:0]};
    if (!op[8])
    begin
      if (ext && op[7:0] <= CCS_IDX_MAX)
        a = idx + {4'h0, op[7:0]};
      else if (op[7:0] <= CCS_IDX_MAX)
        a = {CCS_ACC_LOW, op[7:0]};
      else
        a = {CCS_ACC_HIGH, op[7:0]};
    end
    return a;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Bus write side: address and data caught in either order
  assign wr_do = aw_full_q && w_full_q && !bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                  {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b1;
      awaddr_q  <= 8'h00;
    end
    else if (CE)
    begin
      if (awready_q && AXI_REQ.awvalid)
      begin
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q  <= AXI_REQ.awaddr;
      end
      else if (wr_do)
      begin
        aw_full_q <= 1'b0;
        awready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      w_full_q <= 1'b0;
      wready_q <= 1'b1;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end
    else if (CE)
    begin
      if (wready_q && AXI_REQ.wvalid)
      begin
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= AXI_REQ.wdata;
        wstrb_q  <= AXI_REQ.wstrb;
      end
      else if (wr_do)
      begin
        w_full_q <= 1'b0;
        wready_q <= 1'b1;
      end
    end
  end

  // Write answer; unmapped offsets get a slave error
  always_comb
  begin
    case (awaddr_q)
      CCS_CTRL_OFS, CCS_WORKING_REG_OFS, CCS_BANK_OFS, CCS_INDEX_OFS,
      CCS_INSTR_OFS, CCS_STAT_OFS, CCS_FADDR_OFS, CCS_FDATA_OFS,
      CCS_WDOG_OFS: wr_ok = 1'b1;
      default:      wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= CCS_RESP_OK;
    end
    else if (CE)
    begin
      if (wr_do)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? CCS_RESP_OK : CCS_RESP_ERR;
      end
      else if (bvalid_q && AXI_REQ.bready)
        bvalid_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Software-steered configuration, byte lanes honoured
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ext_q   <= CCS_EXT_RST;
      bank_q  <= CCS_BANK_RST;
      index_q <= CCS_INDEX_RST;
      faddr_q <= CCS_FADDR_RST;
    end
    else if (CE && wr_do)
    begin
      case (awaddr_q)
        CCS_CTRL_OFS:
          if (wstrb_q[0])
            ext_q <= wdata_q[CCS_CTRL_EXT];
        CCS_BANK_OFS:
          if (wstrb_q[0])
            bank_q <= wdata_q[3:0];
        CCS_INDEX_OFS:
          index_q <= (wdata_q[11:0] & wmask[11:0]) |
                     (index_q & ~wmask[11:0]);
        CCS_FADDR_OFS:
          faddr_q <= (wdata_q[11:0] & wmask[11:0]) |
                     (faddr_q & ~wmask[11:0]);
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sequencer: a write to the instruction register starts a cycle
  // while idle; later writes are dropped until it is done
  assign start = CE && wr_do && awaddr_q == CCS_INSTR_OFS &&
                 wstrb_q[0] && wstrb_q[1] && state_q == CCS_IDLE;
  assign q_end = qtr_q == CCS_QTR_LAST;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      state_q <= CCS_IDLE;
      qtr_q   <= 2'h0;
      ir_q    <= 16'h0000;
      two_q   <= 1'b0;
    end
    else if (CE)
    begin
      case (state_q)
        CCS_IDLE:
          if (start)
          begin
            ir_q    <= wdata_q[15:0];
            two_q   <= wdata_q[CCS_INSTR_TWO] & wstrb_q[2];
            qtr_q   <= 2'h0;
            state_q <= CCS_EXEC;
          end
        CCS_EXEC:
        begin
          qtr_q <= qtr_q + 2'h1;
          if (q_end)
            state_q <= take_q ? CCS_SKIP1 : CCS_IDLE;
        end
        CCS_SKIP1:
        begin
          qtr_q <= qtr_q + 2'h1;
          if (q_end)
            state_q <= two_q ? CCS_SKIP2 : CCS_IDLE;
        end
        CCS_SKIP2:
        begin
          qtr_q <= qtr_q + 2'h1;
          if (q_end)
            state_q <= CCS_IDLE;
        end
        default: state_q <= CCS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Quarter work: Q1 decode, Q2 read, Q3 process, Q4 write
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      kind_q <= CCS_K_NONE;
      ea_q   <= 12'h000;
      opnd_q <= 8'h00;
      res_q  <= 8'h00;
      take_q <= 1'b0;
    end
    else if (CE && state_q == CCS_EXEC)
    begin
      case (qtr_q)
        2'h0:
        begin
          kind_q <= decode(ir_q);
          ea_q   <= eff_addr(ir_q, ext_q, bank_q, index_q);
          take_q <= 1'b0;
        end
        2'h1: opnd_q <= mem[ea_q];
        2'h2:
        begin
          res_q <= ~opnd_q;
          // Unsigned compare; nothing of it is kept
          case (kind_q)
            CCS_K_CPFEQ: take_q <= opnd_q == working_reg_q;
            CCS_K_CPFGT: take_q <= opnd_q > working_reg_q;
            CCS_K_CPFLT: take_q <= opnd_q < working_reg_q;
            default:     take_q <= 1'b0;
          endcase
        end
        default: ; // Compares write nothing here
      endcase
    end
  end

  // File write of a complement only in the fourth quarter
  assign mem_we = state_q == CCS_EXEC && q_end &&
                  kind_q == CCS_K_COMPLEMENT_REG_INSTR && ir_q[9];

  // Data memory; the core wins over a bus write in the same cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (CE)
    begin
      if (mem_we)
        mem[ea_q] <= res_q;
      else if (wr_do && awaddr_q == CCS_FDATA_OFS && wstrb_q[0])
        mem[faddr_q] <= wdata_q[7:0];
    end
  end

  // Working register: complement with d=0 beats a bus write
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      working_reg_q <= CCS_WORKING_REG_RST;
    else if (CE)
    begin
      if (state_q == CCS_EXEC && q_end && kind_q == CCS_K_COMPLEMENT_REG_INSTR &&
          !ir_q[9])
        working_reg_q <= res_q;
      else if (wr_do && awaddr_q == CCS_WORKING_REG_OFS && wstrb_q[0])
        working_reg_q <= wdata_q[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Status flags; hardware updates are placed last so they win
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      neg_q  <= 1'b0;
      zero_q <= 1'b0;
      to_n_q <= CCS_FLAGN_RST;
      pd_n_q <= CCS_FLAGN_RST;
    end
    else if (CE)
    begin
      if (wr_do && awaddr_q == CCS_STAT_OFS && wstrb_q[0])
      begin
        neg_q  <= wdata_q[CCS_ST_NEG];
        zero_q <= wdata_q[CCS_ST_ZERO];
        to_n_q <= wdata_q[CCS_ST_TO];
        pd_n_q <= wdata_q[CCS_ST_PD];
      end
      if (state_q == CCS_EXEC && q_end && kind_q == CCS_K_COMPLEMENT_REG_INSTR)
      begin
        neg_q  <= res_q[7];
        zero_q <= res_q == 8'h00;
      end
      if (wd_clr)
      begin
        to_n_q <= 1'b1;
        pd_n_q <= 1'b1;
      end
    end
  end

  // Outcome of the last instruction; cycle count held until the next start, bad flag until the next instruction's read quarter, skip flag follows the state
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      bad_q  <= 1'b0;
      skip_q <= 1'b0;
      cyc_q  <= 2'h0;
    end
    else if (CE)
    begin
      if (start)
        cyc_q <= 2'h0;
      else if (state_q != CCS_IDLE && q_end)
        cyc_q <= cyc_q + 2'h1;
      if (state_q == CCS_EXEC && qtr_q == 2'h1)
        bad_q <= kind_q == CCS_K_NONE;
      skip_q <= state_q == CCS_SKIP1 || state_q == CCS_SKIP2 ||
                (state_q == CCS_EXEC && q_end && take_q);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Watchdog: cleared in the process quarter of the clear
  assign wd_clr  = state_q == CCS_EXEC && qtr_q == 2'h2 &&
                   kind_q == CCS_K_WDCLR;
  assign wd_tick = state_q != CCS_IDLE && q_end;

  ccs_wdog u_wdog (
    .clk     (CLK_SYS),
    .rst     (RST),
    .ce      (CE),
    .tick    (wd_tick),
    .clr     (wd_clr),
    .count_q (wd_cnt),
    .post_q  (wd_post)
  );

  //////////////////////////////////////////////////////////////////////
  // Bus read side; data sampled at the address handshake
  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h00000000;
    case (AXI_REQ.araddr)
      CCS_CTRL_OFS:  rd_word[CCS_CTRL_EXT] = ext_q;
      CCS_WORKING_REG_OFS:  rd_word[7:0] = working_reg_q;
      CCS_BANK_OFS:  rd_word[3:0] = bank_q;
      CCS_INDEX_OFS: rd_word[11:0] = index_q;
      CCS_INSTR_OFS: rd_word[16:0] = {two_q, ir_q};
      CCS_STAT_OFS:
      begin
        rd_word[CCS_ST_BUSY] = state_q != CCS_IDLE;
        rd_word[CCS_ST_SKIP] = skip_q;
        rd_word[CCS_ST_NEG]  = neg_q;
        rd_word[CCS_ST_ZERO] = zero_q;
        rd_word[CCS_ST_TO]   = to_n_q;
        rd_word[CCS_ST_PD]   = pd_n_q;
        rd_word[CCS_ST_BAD]  = bad_q;
        rd_word[CCS_ST_CYC+1:CCS_ST_CYC] = cyc_q;
      end
      CCS_FADDR_OFS: rd_word[11:0] = faddr_q;
      CCS_FDATA_OFS: rd_word[7:0] = mem[faddr_q];
      CCS_WDOG_OFS:  rd_word[11:0] = {wd_post, wd_cnt};
      default:       rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= CCS_RESP_OK;
    end
    else if (CE)
    begin
      if (arready_q && AXI_REQ.arvalid)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_word;
        rresp_q   <= rd_ok ? CCS_RESP_OK : CCS_RESP_ERR;
      end
      else if (rvalid_q && AXI_REQ.rready)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      BUSY      <= 1'b0;
      SKIP      <= 1'b0;
      WDOG_CNT  <= 8'h00;
      WDOG_POST <= 4'h0;
    end
    else if (CE)
    begin
      BUSY      <= state_q != CCS_IDLE;
      SKIP      <= state_q == CCS_SKIP1 || state_q == CCS_SKIP2;
      WDOG_CNT  <= wd_cnt;
      WDOG_POST <= wd_post;
    end
  end

  assign AXI_RSP.awready = awready_q;
  assign AXI_RSP.wready  = wready_q;
  assign AXI_RSP.bresp   = bresp_q;
  assign AXI_RSP.bvalid  = bvalid_q;
  assign AXI_RSP.arready = arready_q;
  assign AXI_RSP.rdata   = rdata_q;
  assign AXI_RSP.rresp   = rresp_q;
  assign AXI_RSP.rvalid  = rvalid_q;

endmodule
`default_nettype wire

// *** bench/ccs_sva.sv ***
// Purpose: Port checker for the compare/skip core
// Assumes: CE high whenever the checks matter
// Notes:   Bound to ccs_core at the foot
`timescale 1ns/100ps
`default_nettype none
module ccs_sva
  import ccs_pkg::*;
(
  input wire logic                  CLK_SYS,   // Clock
  input wire logic                  RST,       // Reset
  input wire logic                  CE,        // Enable
  input wire ccs_pkg::ccs_axi_req_t AXI_REQ,   // Bus in
  input wire ccs_pkg::ccs_axi_rsp_t AXI_RSP,   // Bus out
  input wire logic [7:0]            WDOG_CNT,  // Counter
  input wire logic [3:0]            WDOG_POST, // Postscaler
  input wire logic                  BUSY,      // Busy
  input wire logic                  SKIP       // Skip
);
  logic [3:0] len_q;

  //////////////////////////////////////////////////////////////////////
  // Busy run length; cleared while idle so each run starts from zero
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
      len_q <= 4'h0;
    else
      len_q <= BUSY ? len_q + 4'h1 : 4'h0;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST || !CE);

  // One no-operation instruction cycle
  sequence nop_s;
    SKIP [*4];
  endsequence

  //////////////////////////////////////////////////////////////////////
  busy_len_a: assert property ($fell(BUSY) |-> len_q inside {4, 8, 12})
    else $error("busy run length wrong");
  skip_start_a: assert property ($rose(SKIP) |-> BUSY && len_q == 4)
    else $error("skip began at wrong time");
  skip_len_a: assert property ($rose(SKIP) |-> nop_s ##1
    ((!SKIP) or (nop_s ##1 !SKIP))) else $error("skip length wrong");
  skip_busy_a: assert property (SKIP |-> BUSY)
    else $error("skip outside busy");
  busy_end_a: assert property ($fell(BUSY) |-> $past(SKIP) == (len_q != 4))
    else $error("skip and length disagree");
  post_wrap_a: assert property ($changed(WDOG_POST) |-> WDOG_CNT == 8'h00)
    else $error("postscaler moved without wrap");
  cnt_step_a: assert property ($changed(WDOG_CNT) |->
    WDOG_CNT == $past(WDOG_CNT) + 8'h01 || WDOG_CNT == 8'h00)
    else $error("counter jumped");
  rd_answer_a: assert property (AXI_REQ.arvalid && AXI_RSP.arready
    |=> AXI_RSP.rvalid) else $error("read answer late");
  wr_answer_a: assert property (AXI_REQ.awvalid && AXI_RSP.awready &&
    AXI_REQ.wvalid && AXI_RSP.wready |-> ##2 AXI_RSP.bvalid)
    else $error("write answer late");
endmodule

bind ccs_core ccs_sva ccs_sva_inst (.CLK_SYS, .RST, .CE, .AXI_REQ,
  .AXI_RSP, .WDOG_CNT, .WDOG_POST, .BUSY, .SKIP);
`default_nettype wire

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the compare/skip core
// Assumes: CE tied high; bready and rready held high
// Notes:   Instructions are issued through the INSTR register
`timescale 1ns/100ps
`default_nettype none
module tb;
  import ccs_pkg::*;
  logic         clk_sys;
  logic         rst;
  ccs_axi_req_t req;
  ccs_axi_rsp_t rsp;
  logic [31:0]  rd;
  logic [1:0]   resp;
  int           err_count;
  int           n_tests;
  // Compare cases: opcode with two-word bit, file, working, cycles
  localparam logic [34:0] CMP_TAB [7] = '{
    {17'h06345, 8'h5a, 8'h5a, 2'h2}, {17'h06345, 8'h5a, 8'h5b, 2'h1},
    {17'h06545, 8'h80, 8'h7f, 2'h2}, {17'h06545, 8'h7f, 8'h7f, 2'h1},
    {17'h16145, 8'h01, 8'hff, 2'h3}, {17'h16145, 8'hff, 8'h01, 2'h1},
    {17'h06145, 8'h00, 8'h01, 2'h2}};

  ccs_core ccs_core_inst (.CLK_SYS(clk_sys), .RST(rst), .CE(1'b1),
    .AXI_REQ(req), .AXI_RSP(rsp), .WDOG_CNT(), .WDOG_POST(), .BUSY(),
    .SKIP());

  //////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk_sys);
      aw = aw | rsp.awready;
      w = w | rsp.wready;
      if (aw)
        req.awvalid <= 1'b0;
      if (w)
        req.wvalid <= 1'b0;
    end
    do @(posedge clk_sys); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
  endtask

  task automatic rdr(input logic [7:0] a);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do @(posedge clk_sys); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_sys); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
  endtask

  // Start an instruction, then poll status until idle
  task automatic run(input logic [16:0] op);
    wr(CCS_INSTR_OFS, {15'h0, op});
    do rdr(CCS_STAT_OFS); while (rd[CCS_ST_BUSY] !== 1'b0);
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the few thousand cycles the tests need
  initial
  begin
    #100000;
    err_count++;
    print_verdict();
  end

  initial
  begin
    req = '0;
    req.wstrb = 4'hf;
    req.bready = 1'b1;
    req.rready = 1'b1;
    err_count = 0;
    n_tests = 0;
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdr(CCS_STAT_OFS);
    chk("stat_rst", rd & 32'hff, 32'h30);
    rdr(CCS_WORKING_REG_OFS);
    chk("working_reg_rst", rd, 32'h0);
    $display("Test reset done");
    // Unknown opcodes tick the watchdog past one counter wrap, so the
    // clear below has a nonzero postscaler to zero
    repeat (260) run(17'h0ffff);
    chk("bad_op", rd & 32'h40, 32'h40);
    rdr(CCS_WDOG_OFS);
    chk("wdog_pre", rd & 32'hfff, 32'h104);
    wr(CCS_STAT_OFS, 32'h04);
    run(17'h00004);
    chk("stat_wdclr", rd & 32'h33c, 32'h134);
    rdr(CCS_WDOG_OFS);
    chk("wdog_post", rd & 32'hf00, 32'h0);
    chk("wdog_cnt", {31'h0, rd[7:0] < 8'h08}, 32'h1);
    $display("Test watchdog clear done");
    wr(CCS_BANK_OFS, 32'h3);
    wr(CCS_FADDR_OFS, 32'h345);
    wr(CCS_FDATA_OFS, 32'h13);
    wr(CCS_WORKING_REG_OFS, 32'h55);
    // Flags opposite to the expected result, so both must move
    wr(CCS_STAT_OFS, 32'h08);
    run(17'h01d45);
    chk("complement_reg_instr_nz", rd & 32'hc, 32'h4);
    rdr(CCS_WORKING_REG_OFS);
    chk("complement_reg_instr_w", rd, 32'hec);
    rdr(CCS_FDATA_OFS);
    chk("complement_reg_instr_keep", rd, 32'h13);
    run(17'h01f45);
    rdr(CCS_FDATA_OFS);
    chk("complement_reg_instr_f", rd, 32'hec);
    wr(CCS_FDATA_OFS, 32'hff);
    run(17'h01f45);
    chk("complement_reg_instr_z", rd & 32'hc, 32'h8);
    rdr(CCS_FDATA_OFS);
    chk("complement_reg_instr_f0", rd, 32'h0);
    wr(CCS_CTRL_OFS, 32'h1);
    wr(CCS_INDEX_OFS, 32'h200);
    wr(CCS_FADDR_OFS, 32'h210);
    wr(CCS_FDATA_OFS, 32'h0f);
    run(17'h01c10);
    rdr(CCS_WORKING_REG_OFS);
    chk("complement_reg_instr_idx", rd, 32'hf0);
    // Same opcode without the extended set lands in the access bank
    wr(CCS_CTRL_OFS, 32'h0);
    wr(CCS_FADDR_OFS, 32'h010);
    wr(CCS_FDATA_OFS, 32'h33);
    run(17'h01c10);
    rdr(CCS_WORKING_REG_OFS);
    chk("complement_reg_instr_acc", rd, 32'hcc);
    $display("Test complement done");
    wr(CCS_FADDR_OFS, 32'h345);
    wr(CCS_STAT_OFS, 32'h3c);
    foreach (CMP_TAB[i])
    begin
      wr(CCS_FDATA_OFS, {24'h0, CMP_TAB[i][17:10]});
      wr(CCS_WORKING_REG_OFS, {24'h0, CMP_TAB[i][9:2]});
      run(CMP_TAB[i][34:18]);
      chk("cmp_cyc", rd & 32'h33c, {22'h0, CMP_TAB[i][1:0], 8'h3c});
      rdr(CCS_WORKING_REG_OFS);
      chk("cmp_w", rd, {24'h0, CMP_TAB[i][9:2]});
      rdr(CCS_FDATA_OFS);
      chk("cmp_f", rd, {24'h0, CMP_TAB[i][17:10]});
    end
    $display("Test compare done");
    rdr(8'h24);
    chk("bad_rd", {rd[29:0], resp}, 32'h2);
    wr(8'h24, 32'h1);
    chk("bad_wr", {30'h0, resp}, 32'h2);
    $display("Test unmapped done");
    print_verdict();
  end
endmodule
`default_nettype wire
